// ===== rtl/sample_queue.sv
// Operation
// R01: Queue holds 128 entries of 40 bits, pressure plus temperature.
// R02: Queue is active for mode codes 001, 011, 101, 110 and 111; mode from trigger bit and field. Mode codes 000, 010 and 100 run as bypass.
// R03: Threshold flag is 1 while count reaches threshold; zero threshold keeps it 0.
// R04: Overwrite flag sets when an unread entry is overwritten.
// R05: Eight-bit unread count, 0 empty, 128 full.
// R06: Modes 000 and 100 store nothing; slot zero is overwritten each sample.
// R07: Selecting bypass clears contents and count.
// R08: Host passes through bypass between two non-bypass modes.
// R09: Mode 001 appends samples until full, then stops storing.
// R10: Depth limit bit caps usable depth at the threshold value.
// R11: Mode 011 never stops; first new sample after emptying is read first.
// R12: In continuous mode the count gives new pairs available.
// R13: Mode 101 bypasses until first event rise, then keeps stop-when-full.
// R14: Mode 110 bypasses until event rise, then keeps continuous.
// R15: Mode 111 runs continuous until event rise, then stop-when-full.
// R16: Host configures the threshold event generator before triggered modes.
// R17: Threshold, overwrite and full conditions routable to the pad by enables.
// R18: Entries read at 78h..7Ch; burst address wraps from 7Ch to 78h.
// R19: Pressure is 24-bit two's complement, low byte at 28h.
// R20: Temperature is 16-bit two's complement, low byte at 2Bh.
// R21: Data-ready indication rises when a new sample pair arrives.
// R22: Auto-increment enable in register 11h, set after reset.
// R23: Reading 7Ch pops the entry and decrements the count.
// R24: Continuous full queue overwrites oldest, count stays at maximum.
// R25: Mode code is trigger bit over the two-bit mode field.
`timescale 1ns/1ps

module staging_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	// Pointers wrap by overflow, so only powers of two are served
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_depth_check
		$error("staging_fifo: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic do_wr;
	logic do_rd;

	assign do_wr = i_in_valid && o_in_ready;
	assign do_rd = o_out_valid && i_out_ready;
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rd_q];

	// Occupancy; ready is registered so it never depends on the source
	always_comb
	begin
		cnt_d = cnt_q;
		if (do_wr && !do_rd)
			cnt_d = cnt_q + 1'b1;
		else if (do_rd && !do_wr)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cnt_q <= '0;
			wr_q <= '0;
			rd_q <= '0;
			o_in_ready <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_d;
			o_in_ready <= (cnt_d < (AW+1)'(DEPTH));
			if (do_wr)
				wr_q <= wr_q + 1'b1;
			if (do_rd)
				rd_q <= rd_q + 1'b1;
		end
	end

	// Storage
	always_ff @(posedge i_clk)
	begin
		if (do_wr)
			mem_q[wr_q] <= i_in_data;
	end

endmodule : staging_fifo

module sample_queue #(
	parameter int DEPTH = 128,
	parameter int STAGE_DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Samples from the measurement chain
	input wire logic i_sample_valid,
	output logic o_sample_ready,
	input wire sample_queue_pkg::sample_t i_sample,
	// Event flag from the threshold generator
	input wire logic i_trigger_event,
	// Register access from the serial front end
	input wire logic i_acc_start,
	input wire logic [6:0] i_acc_addr,
	input wire logic i_acc_wr,
	input wire logic [7:0] i_acc_wdata,
	input wire logic i_acc_rd,
	output logic [7:0] o_acc_rdata,
	output logic o_acc_rvalid,
	// Pad and indications
	output logic o_ready_event_pad,
	output logic o_data_ready
);
	localparam int AW = $clog2(DEPTH);

	// The eight-bit count encoding only fits a depth of 128
	if (DEPTH != 128)
	begin : g_depth_check
		$error("sample_queue: count encoding serves a depth of 128 only");
	end

	// Register file
	logic [7:0] event_setup_q;
	logic [7:0] secondary_control_q;
	logic [7:0] routing_control_q;
	logic [7:0] queue_control_q;
	logic [7:0] queue_threshold_q;
	logic [6:0] addr_q;

	// Queue state
	sample_queue_pkg::sample_t mem_q [DEPTH];
	sample_queue_pkg::sample_t last_q;
	logic [AW-1:0] head_q;
	logic [AW-1:0] tail_q;
	logic [7:0] unread_entry_count_q;
	logic overwrite_flag_q;
	logic trig_seen_q;
	logic trig_prev_q;
	logic ready_flag_q;

	// Decoded controls
	logic [2:0] mode_code;
	logic [6:0] queue_threshold_value;
	logic [7:0] limit;
	logic threshold_reached_flag;
	logic full;
	logic wr_ctrl;
	logic go_bypass;
	logic rd_now;
	logic pop;
	logic push;
	logic stage_valid;
	logic stage_ready;
	sample_queue_pkg::sample_t stage_data;
	sample_queue_pkg::behaviour_t beh;
	logic [7:0] rd_byte;

	assign mode_code = {queue_control_q[sample_queue_pkg::QC_TRIGGER_MODE_BIT],
		queue_control_q[sample_queue_pkg::QC_MODE_LSB +: 2]}; // [R25]
	assign queue_threshold_value = queue_threshold_q[6:0];
	assign limit = queue_control_q[sample_queue_pkg::QC_DEPTH_LIMIT_BIT] ?
		{1'b0, queue_threshold_value} : 8'(DEPTH); // [R10]
	assign full = (unread_entry_count_q >= limit);
	assign threshold_reached_flag = (queue_threshold_value != 7'h00) &&
		(unread_entry_count_q >= {1'b0, queue_threshold_value}); // [R03]
	assign wr_ctrl = i_acc_wr && (addr_q == sample_queue_pkg::ADDR_QUEUE_CONTROL);
	assign go_bypass = wr_ctrl && (i_acc_wdata[2:0] == sample_queue_pkg::MODE_BYPASS
		|| i_acc_wdata[2:0] == 3'h4); // [R07]
	assign rd_now = i_acc_rd && !i_acc_wr;
	assign pop = rd_now && (addr_q == sample_queue_pkg::ADDR_QUEUE_LAST)
		&& (unread_entry_count_q != 8'h00); // [R23]
	// A pop stalls the stage, so push and pop never share a cycle
	assign stage_ready = !pop;
	assign push = stage_valid && stage_ready;

	// Effective behaviour; zero control register falls into bypass
	always_comb
	begin
		case (mode_code) // [R02]
			sample_queue_pkg::MODE_KEEP: beh = sample_queue_pkg::BEH_KEEP; // [R09]
			sample_queue_pkg::MODE_CONT: beh = sample_queue_pkg::BEH_CONT; // [R11]
			sample_queue_pkg::MODE_BYP_TO_KEEP: beh = trig_seen_q ?
				sample_queue_pkg::BEH_KEEP : sample_queue_pkg::BEH_BYPASS; // [R13]
			sample_queue_pkg::MODE_BYP_TO_CONT: beh = trig_seen_q ?
				sample_queue_pkg::BEH_CONT : sample_queue_pkg::BEH_BYPASS; // [R14]
			sample_queue_pkg::MODE_CONT_TO_KEEP: beh = trig_seen_q ?
				sample_queue_pkg::BEH_KEEP : sample_queue_pkg::BEH_CONT; // [R15]
			default: beh = sample_queue_pkg::BEH_BYPASS; // [R06]
		endcase
	end

	// Sample staging; back-pressure reaches the measurement chain
	staging_fifo #(
		.WIDTH($bits(sample_queue_pkg::sample_t)),
		.DEPTH(STAGE_DEPTH)
	) u_stage (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_in_valid(i_sample_valid),
		.o_in_ready(o_sample_ready),
		.i_in_data(i_sample),
		.o_out_valid(stage_valid),
		.i_out_ready(stage_ready),
		.o_out_data(stage_data)
	);

	// Writable registers
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			event_setup_q <= sample_queue_pkg::RST_EVENT_SETUP;
			secondary_control_q <= sample_queue_pkg::RST_SECONDARY_CONTROL; // [R22]
			routing_control_q <= sample_queue_pkg::RST_ROUTING_CONTROL;
			queue_control_q <= sample_queue_pkg::RST_QUEUE_CONTROL;
			queue_threshold_q <= sample_queue_pkg::RST_QUEUE_THRESHOLD;
		end
		else if (i_acc_wr)
		begin
			case (addr_q)
				sample_queue_pkg::ADDR_EVENT_SETUP: event_setup_q <= i_acc_wdata;
				sample_queue_pkg::ADDR_SECONDARY_CONTROL: secondary_control_q <= i_acc_wdata;
				sample_queue_pkg::ADDR_ROUTING_CONTROL: routing_control_q <= i_acc_wdata;
				sample_queue_pkg::ADDR_QUEUE_CONTROL: queue_control_q <= i_acc_wdata;
				sample_queue_pkg::ADDR_QUEUE_THRESHOLD: queue_threshold_q <= i_acc_wdata;
				default: ;
			endcase
		end
	end

	// Access address; burst wraps inside the queue output window
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			addr_q <= 7'h00;
		else if (i_acc_start)
			addr_q <= i_acc_addr;
		else if ((i_acc_rd || i_acc_wr)
			&& secondary_control_q[sample_queue_pkg::SC_AUTO_INC_BIT]) // [R22]
		begin
			if (addr_q == sample_queue_pkg::ADDR_QUEUE_LAST)
				addr_q <= sample_queue_pkg::ADDR_QUEUE_FIRST; // [R18]
			else
				addr_q <= addr_q + 7'h01;
		end
	end

	// Trigger latch: first rise switches triggered modes until the next control write
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			trig_prev_q <= 1'b0;
			trig_seen_q <= 1'b0;
		end
		else
		begin
			trig_prev_q <= i_trigger_event;
			if (i_trigger_event && !trig_prev_q)
				trig_seen_q <= 1'b1; // [R13] [R14] [R15]
			else if (wr_ctrl)
				trig_seen_q <= 1'b0;
		end
	end

	// Pointers and unread count
	always_ff @(posedge i_clk)
	begin
		if (i_srst || go_bypass || beh == sample_queue_pkg::BEH_BYPASS)
		begin
			head_q <= '0; // [R06] [R07]
			tail_q <= '0;
			unread_entry_count_q <= 8'h00;
		end
		else if (pop)
		begin
			head_q <= head_q + 1'b1; // [R23]
			unread_entry_count_q <= unread_entry_count_q - 8'h01;
		end
		else if (push && !full)
		begin
			tail_q <= tail_q + 1'b1; // [R09] [R11] [R12]
			unread_entry_count_q <= unread_entry_count_q + 8'h01;
		end
		else if (push && beh == sample_queue_pkg::BEH_CONT
			&& unread_entry_count_q != 8'h00)
		begin
			// Oldest entry is lost, count holds at its ceiling
			tail_q <= tail_q + 1'b1; // [R24]
			head_q <= head_q + 1'b1;
		end
	end

	// Entry storage; bypass keeps refreshing slot zero
	always_ff @(posedge i_clk)
	begin
		if (push && (beh == sample_queue_pkg::BEH_BYPASS || !full
			|| beh == sample_queue_pkg::BEH_CONT))
			mem_q[beh == sample_queue_pkg::BEH_BYPASS ? '0 : tail_q] <= stage_data; // [R01]
	end

	// Overwrite flag: set wins over read-clear and bypass-clear
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			overwrite_flag_q <= 1'b0;
		else if (push && full && beh == sample_queue_pkg::BEH_CONT
			&& unread_entry_count_q != 8'h00)
			overwrite_flag_q <= 1'b1; // [R04]
		else if (go_bypass || (rd_now && addr_q == sample_queue_pkg::ADDR_FLAG_STATUS))
			overwrite_flag_q <= 1'b0;
	end

	// Latest sample and data-ready; a new sample beats the clearing read
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			last_q <= '0;
			ready_flag_q <= 1'b0;
		end
		else if (push)
		begin
			last_q <= stage_data; // [R19] [R20]
			ready_flag_q <= 1'b1; // [R21]
		end
		else if (rd_now && addr_q == sample_queue_pkg::ADDR_TEMP_HIGH)
			ready_flag_q <= 1'b0;
	end

	// Read data selection
	always_comb
	begin
		sample_queue_pkg::sample_t q;
		q = mem_q[head_q];
		rd_byte = 8'h00;
		case (addr_q)
			sample_queue_pkg::ADDR_EVENT_SETUP: rd_byte = event_setup_q;
			sample_queue_pkg::ADDR_SECONDARY_CONTROL: rd_byte = secondary_control_q;
			sample_queue_pkg::ADDR_ROUTING_CONTROL: rd_byte = routing_control_q;
			sample_queue_pkg::ADDR_QUEUE_CONTROL: rd_byte = queue_control_q;
			sample_queue_pkg::ADDR_QUEUE_THRESHOLD: rd_byte = queue_threshold_q;
			sample_queue_pkg::ADDR_EVENT_SOURCE:
				rd_byte[sample_queue_pkg::ES_TRIGGER_EVENT_BIT] = trig_prev_q;
			sample_queue_pkg::ADDR_LEVEL_STATUS: rd_byte = unread_entry_count_q; // [R05]
			sample_queue_pkg::ADDR_FLAG_STATUS:
			begin
				rd_byte[sample_queue_pkg::FS_THRESHOLD_BIT] = threshold_reached_flag;
				rd_byte[sample_queue_pkg::FS_OVERWRITE_BIT] = overwrite_flag_q;
				rd_byte[sample_queue_pkg::FS_FULL_BIT] = (unread_entry_count_q == 8'(DEPTH));
			end
			sample_queue_pkg::ADDR_PRESS_LOW: rd_byte = last_q.press[7:0]; // [R19]
			sample_queue_pkg::ADDR_PRESS_MID: rd_byte = last_q.press[15:8];
			sample_queue_pkg::ADDR_PRESS_HIGH: rd_byte = last_q.press[23:16];
			sample_queue_pkg::ADDR_TEMP_LOW: rd_byte = last_q.temp[7:0]; // [R20]
			sample_queue_pkg::ADDR_TEMP_HIGH: rd_byte = last_q.temp[15:8];
			sample_queue_pkg::ADDR_QUEUE_FIRST: rd_byte = q.press[7:0]; // [R18]
			sample_queue_pkg::ADDR_QUEUE_PRESS_MID: rd_byte = q.press[15:8];
			sample_queue_pkg::ADDR_QUEUE_PRESS_HIGH: rd_byte = q.press[23:16];
			sample_queue_pkg::ADDR_QUEUE_TEMP_LOW: rd_byte = q.temp[7:0];
			sample_queue_pkg::ADDR_QUEUE_LAST: rd_byte = q.temp[15:8];
			default: rd_byte = 8'h00;
		endcase
	end

	// Read answer, one cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_acc_rdata <= 8'h00;
			o_acc_rvalid <= 1'b0;
		end
		else
		begin
			o_acc_rvalid <= rd_now;
			if (rd_now)
				o_acc_rdata <= rd_byte;
		end
	end

	// Pad routing of enabled conditions
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_ready_event_pad <= 1'b0;
			o_data_ready <= 1'b0;
		end
		else
		begin
			o_data_ready <= ready_flag_q; // [R21]
			o_ready_event_pad <=
				(routing_control_q[sample_queue_pkg::RC_READY_PAD_BIT] && ready_flag_q)
				|| (routing_control_q[sample_queue_pkg::RC_OVERWRITE_PAD_BIT]
				&& overwrite_flag_q)
				|| (routing_control_q[sample_queue_pkg::RC_THRESHOLD_PAD_BIT]
				&& threshold_reached_flag)
				|| (routing_control_q[sample_queue_pkg::RC_FULL_PAD_BIT]
				&& unread_entry_count_q == 8'(DEPTH)); // [R17]
		end
	end

	AST_COUNT_MAX: assert property (@(posedge i_clk) disable iff (i_srst) // [R05]
		unread_entry_count_q <= 8'h80)
		else $error("unread count above 128");

	AST_BYPASS_EMPTY: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
		beh == sample_queue_pkg::BEH_BYPASS |=> unread_entry_count_q == 8'h00)
		else $error("bypass left entries queued");

	AST_THRESHOLD: assert property (@(posedge i_clk) disable iff (i_srst) // [R03]
		rd_now && addr_q == sample_queue_pkg::ADDR_FLAG_STATUS
		&& queue_threshold_q[6:0] == 7'h00
		|=> !o_acc_rdata[sample_queue_pkg::FS_THRESHOLD_BIT])
		else $error("threshold flag set with zero threshold");

	AST_OVERWRITE: assert property (@(posedge i_clk) disable iff (i_srst) // [R04]
		push && full && unread_entry_count_q != 8'h00
		&& beh == sample_queue_pkg::BEH_CONT |=> overwrite_flag_q)
		else $error("overwrite flag missed");

	AST_KEEP_STOP: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
		push && full && beh == sample_queue_pkg::BEH_KEEP && !wr_ctrl
		|=> $stable(unread_entry_count_q) && $stable(tail_q))
		else $error("stop-when-full stored past its depth");

	AST_POP: assert property (@(posedge i_clk) disable iff (i_srst) // [R23]
		pop && !go_bypass && beh != sample_queue_pkg::BEH_BYPASS
		|=> unread_entry_count_q == $past(unread_entry_count_q) - 8'h01)
		else $error("read of last byte did not pop");

	AST_WRAP: assert property (@(posedge i_clk) disable iff (i_srst) // [R18]
		i_acc_rd && !i_acc_start && addr_q == sample_queue_pkg::ADDR_QUEUE_LAST
		&& secondary_control_q[sample_queue_pkg::SC_AUTO_INC_BIT]
		|=> addr_q == sample_queue_pkg::ADDR_QUEUE_FIRST)
		else $error("burst address did not wrap");

	AST_CONT_FULL: assert property (@(posedge i_clk) disable iff (i_srst) // [R24]
		push && beh == sample_queue_pkg::BEH_CONT && unread_entry_count_q == 8'h80
		&& !wr_ctrl |=> unread_entry_count_q == 8'h80)
		else $error("continuous full count dropped");

	AST_TRIG_KEEP: assert property (@(posedge i_clk) disable iff (i_srst) // [R13]
		trig_seen_q && !wr_ctrl |=> trig_seen_q)
		else $error("trigger switch was lost");

	AST_READ_ANSWER: assert property (@(posedge i_clk) disable iff (i_srst) // [R19]
		rd_now && addr_q == sample_queue_pkg::ADDR_PRESS_LOW
		|=> o_acc_rvalid && o_acc_rdata == $past(last_q.press[7:0]))
		else $error("pressure low byte answer wrong");

endmodule : sample_queue

// ===== rtl/sample_queue_pkg.sv
package sample_queue_pkg;

	// Register offsets (7-bit register space)
	localparam logic [6:0] ADDR_EVENT_SETUP = 7'h0B;
	localparam logic [6:0] ADDR_SECONDARY_CONTROL = 7'h11;
	localparam logic [6:0] ADDR_ROUTING_CONTROL = 7'h12;
	localparam logic [6:0] ADDR_QUEUE_CONTROL = 7'h13;
	localparam logic [6:0] ADDR_QUEUE_THRESHOLD = 7'h14;
	localparam logic [6:0] ADDR_EVENT_SOURCE = 7'h24;
	localparam logic [6:0] ADDR_LEVEL_STATUS = 7'h25;
	localparam logic [6:0] ADDR_FLAG_STATUS = 7'h26;
	localparam logic [6:0] ADDR_PRESS_LOW = 7'h28;
	localparam logic [6:0] ADDR_PRESS_MID = 7'h29;
	localparam logic [6:0] ADDR_PRESS_HIGH = 7'h2A;
	localparam logic [6:0] ADDR_TEMP_LOW = 7'h2B;
	localparam logic [6:0] ADDR_TEMP_HIGH = 7'h2C;
	localparam logic [6:0] ADDR_QUEUE_FIRST = 7'h78;
	localparam logic [6:0] ADDR_QUEUE_PRESS_MID = 7'h79;
	localparam logic [6:0] ADDR_QUEUE_PRESS_HIGH = 7'h7A;
	localparam logic [6:0] ADDR_QUEUE_TEMP_LOW = 7'h7B;
	localparam logic [6:0] ADDR_QUEUE_LAST = 7'h7C;

	// Field positions
	localparam int QC_MODE_LSB = 0;
	localparam int QC_TRIGGER_MODE_BIT = 2;
	localparam int QC_DEPTH_LIMIT_BIT = 3;
	localparam int SC_AUTO_INC_BIT = 4;
	localparam int RC_READY_PAD_BIT = 2;
	localparam int RC_OVERWRITE_PAD_BIT = 3;
	localparam int RC_THRESHOLD_PAD_BIT = 4;
	localparam int RC_FULL_PAD_BIT = 5;
	localparam int ES_TRIGGER_EVENT_BIT = 2;
	localparam int FS_THRESHOLD_BIT = 7;
	localparam int FS_OVERWRITE_BIT = 6;
	localparam int FS_FULL_BIT = 5;

	// Reset values
	localparam logic [7:0] RST_EVENT_SETUP = 8'h00;
	localparam logic [7:0] RST_SECONDARY_CONTROL = 8'h10;
	localparam logic [7:0] RST_ROUTING_CONTROL = 8'h00;
	localparam logic [7:0] RST_QUEUE_CONTROL = 8'h00;
	localparam logic [7:0] RST_QUEUE_THRESHOLD = 8'h00;

	// Mode codes: trigger bit above the two-bit mode field
	localparam logic [2:0] MODE_BYPASS = 3'h0;
	localparam logic [2:0] MODE_KEEP = 3'h1;
	localparam logic [2:0] MODE_CONT = 3'h3;
	localparam logic [2:0] MODE_BYP_TO_KEEP = 3'h5;
	localparam logic [2:0] MODE_BYP_TO_CONT = 3'h6;
	localparam logic [2:0] MODE_CONT_TO_KEEP = 3'h7;

	// Effective queue behaviour
	typedef enum logic [2:0] {
		BEH_BYPASS = 3'b001,
		BEH_KEEP = 3'b010,
		BEH_CONT = 3'b100
	} behaviour_t;

	// One pressure and temperature pair
	typedef struct packed {
		logic [15:0] temp;
		logic [23:0] press;
	} sample_t;

endpackage : sample_queue_pkg

// ===== sim/host_port_model.sv
`timescale 1ns/1ps

module host_port_model (
	// Clock
	input wire logic i_clk,
	// Access strobes towards the block
	output logic o_acc_start,
	output logic [6:0] o_acc_addr,
	output logic o_acc_wr,
	output logic [7:0] o_acc_wdata,
	output logic o_acc_rd,
	// Read answer
	input wire logic [7:0] i_acc_rdata,
	input wire logic i_acc_rvalid
);
	// Bytes of the last read burst, unknown where no answer came
	logic [7:0] got[$];

	// Idle strobes from time zero
	initial
	begin
		o_acc_start = 1'b0;
		o_acc_addr = 7'h00;
		o_acc_wr = 1'b0;
		o_acc_wdata = 8'h00;
		o_acc_rd = 1'b0;
	end

	// Address load, then one read per cycle; auto-increment walks the address
	task burst(input logic [6:0] a, input int n);
		got.delete();
		@(negedge i_clk);
		o_acc_start = 1'b1;
		o_acc_addr = a;
		@(negedge i_clk);
		o_acc_start = 1'b0;
		o_acc_rd = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			@(negedge i_clk);
			if (i == n - 1)
				o_acc_rd = 1'b0;
			got.push_back(i_acc_rvalid ? i_acc_rdata : 8'hXX);
		end
	endtask : burst

	// Single write; stale data is inverted so it is never mistaken for valid
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_acc_start = 1'b1;
		o_acc_addr = a;
		@(negedge i_clk);
		o_acc_start = 1'b0;
		o_acc_wr = 1'b1;
		o_acc_wdata = d;
		@(negedge i_clk);
		o_acc_wr = 1'b0;
		o_acc_wdata = ~d;
	endtask : wr

	// Mode change always passes through bypass first
	task set_mode(input logic [7:0] v);
		wr(sample_queue_pkg::ADDR_QUEUE_CONTROL, 8'h00); // Bypass between modes
		if (v[2])
			wr(sample_queue_pkg::ADDR_EVENT_SETUP, 8'h01); // Event generator set up
		wr(sample_queue_pkg::ADDR_QUEUE_CONTROL, v);
	endtask : set_mode

endmodule : host_port_model

// ===== sim/tb_pressure_temp_sample_fifo.sv
`timescale 1ns/1ps

`define CHK(got_v, exp_v) \
	begin \
		samples_checked++; \
		if ((got_v) !== (exp_v)) \
		begin \
			miscompares++; \
			$display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v); \
		end \
	end

module tb_pressure_temp_sample_fifo;
	logic i_clk;
	logic i_srst;
	logic i_sample_valid;
	logic o_sample_ready;
	sample_queue_pkg::sample_t i_sample;
	logic i_trigger_event;
	logic acc_start;
	logic [6:0] acc_addr;
	logic acc_wr;
	logic [7:0] acc_wdata;
	logic acc_rd;
	logic [7:0] acc_rdata;
	logic acc_rvalid;
	logic o_ready_event_pad;
	logic o_data_ready;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [2:0] tmodes[3] = '{3'h5, 3'h6, 3'h7};
	logic [7:0] tbefore[3] = '{8'h00, 8'h00, 8'h02};

	sample_queue #(
		.DEPTH(128),
		.STAGE_DEPTH(8)
	) DUT (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_sample_valid(i_sample_valid),
		.o_sample_ready(o_sample_ready),
		.i_sample(i_sample),
		.i_trigger_event(i_trigger_event),
		.i_acc_start(acc_start),
		.i_acc_addr(acc_addr),
		.i_acc_wr(acc_wr),
		.i_acc_wdata(acc_wdata),
		.i_acc_rd(acc_rd),
		.o_acc_rdata(acc_rdata),
		.o_acc_rvalid(acc_rvalid),
		.o_ready_event_pad(o_ready_event_pad),
		.o_data_ready(o_data_ready)
	);

	host_port_model host (
		.i_clk(i_clk),
		.o_acc_start(acc_start),
		.o_acc_addr(acc_addr),
		.o_acc_wr(acc_wr),
		.o_acc_wdata(acc_wdata),
		.o_acc_rd(acc_rd),
		.i_acc_rdata(acc_rdata),
		.i_acc_rvalid(acc_rvalid)
	);

	// Free-running core clock
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Distinct negative readings so sign bits and byte order both show
	function automatic sample_queue_pkg::sample_t mk(input int k);
		mk.press = 24'hC00000 | 24'(k);
		mk.temp = 16'h8000 | 16'(k * 3);
	endfunction : mk

	task results;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task expect_reg(input logic [6:0] a, input logic [7:0] e);
		host.burst(a, 1);
		`CHK(host.got[0], e)
	endtask : expect_reg

	// Five queue bytes in wire order: pressure low first, temperature high last
	task chk_entry(input int off, input sample_queue_pkg::sample_t s);
		for (int i = 0; i < 5; i++)
			`CHK(host.got[off + i], s[8 * i +: 8])
	endtask : chk_entry

	// Back-to-back offers, each held until the staging buffer takes it
	task push(input int k, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge i_clk);
			i_sample_valid = 1'b1;
			i_sample = mk(k + i);
			// Ready is settled here and holds until the edge that takes the pair
			while (o_sample_ready !== 1'b1)
				@(negedge i_clk);
		end
		@(negedge i_clk);
		i_sample_valid = 1'b0;
		repeat (16) @(negedge i_clk);
	endtask : push

	// Hang guard, well above the roughly 800 cycles the tests need
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			results();
		end
	end

	// Main sequence
	initial
	begin
		i_srst = 1'b1;
		i_sample_valid = 1'b0;
		i_sample = '0;
		i_trigger_event = 1'b0;
		repeat (8) @(negedge i_clk);
		i_srst = 1'b0;

		expect_reg(sample_queue_pkg::ADDR_SECONDARY_CONTROL, 8'h10); // Auto-increment on
		expect_reg(sample_queue_pkg::ADDR_EVENT_SETUP, 8'h00); // Reset value
		expect_reg(sample_queue_pkg::ADDR_ROUTING_CONTROL, 8'h00); // Reset value
		expect_reg(sample_queue_pkg::ADDR_QUEUE_CONTROL, 8'h00); // Reset value
		expect_reg(sample_queue_pkg::ADDR_QUEUE_THRESHOLD, 8'h00); // Reset value
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h00); // Empty count
		expect_reg(7'h50, 8'h00); // Unmapped reads zero
		`CHK(o_sample_ready, 1'b1) // Staging accepts after reset
		$display("test reset done");

		push(1, 3);
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h00); // Bypass stays empty
		`CHK(o_data_ready, 1'b1) // New pair flagged
		host.burst(sample_queue_pkg::ADDR_PRESS_LOW, 5);
		chk_entry(0, mk(3)); // Latest pair in output bytes
		repeat (3) @(negedge i_clk);
		`CHK(o_data_ready, 1'b0) // Cleared by high temperature read
		$display("test bypass done");

		host.wr(sample_queue_pkg::ADDR_QUEUE_THRESHOLD, 8'h04);
		host.set_mode(8'h09);
		push(1, 6);
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h04); // Depth capped
		expect_reg(sample_queue_pkg::ADDR_FLAG_STATUS, 8'h80); // Threshold reached
		host.burst(sample_queue_pkg::ADDR_QUEUE_FIRST, 10);
		chk_entry(0, mk(1)); // Oldest first
		chk_entry(5, mk(2)); // Wrap to first byte and pop
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h02); // Two pops
		expect_reg(sample_queue_pkg::ADDR_FLAG_STATUS, 8'h00); // Below threshold
		$display("test limited done");

		host.wr(sample_queue_pkg::ADDR_QUEUE_CONTROL, 8'h00);
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h00); // Bypass clears
		host.wr(sample_queue_pkg::ADDR_QUEUE_THRESHOLD, 8'h00);
		host.wr(sample_queue_pkg::ADDR_QUEUE_CONTROL, 8'h01);
		push(10, 130);
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h80); // Full at 128
		expect_reg(sample_queue_pkg::ADDR_FLAG_STATUS, 8'h20); // Zero threshold, no overrun
		host.wr(sample_queue_pkg::ADDR_ROUTING_CONTROL, 8'h20);
		repeat (2) @(negedge i_clk);
		`CHK(o_ready_event_pad, 1'b1) // Full routed to pad
		host.wr(sample_queue_pkg::ADDR_ROUTING_CONTROL, 8'h00);
		repeat (2) @(negedge i_clk);
		`CHK(o_ready_event_pad, 1'b0) // Routing disabled
		host.burst(sample_queue_pkg::ADDR_QUEUE_FIRST, 5);
		chk_entry(0, mk(10)); // Later samples dropped, first kept
		$display("test full done");

		host.set_mode(8'h03);
		push(200, 130);
		expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, 8'h80); // Count stays at maximum
		expect_reg(sample_queue_pkg::ADDR_FLAG_STATUS, 8'h60); // Overrun and full
		expect_reg(sample_queue_pkg::ADDR_FLAG_STATUS, 8'h20); // Overrun cleared by read
		host.burst(sample_queue_pkg::ADDR_QUEUE_FIRST, 5);
		chk_entry(0, mk(202)); // Oldest two overwritten
		$display("test continuous done");

		for (int m = 0; m < 3; m++)
		begin
			i_trigger_event = 1'b0;
			host.set_mode({5'h00, tmodes[m]});
			push(400, 2);
			expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, tbefore[m]); // Before event
			i_trigger_event = 1'b1;
			repeat (4) @(negedge i_clk);
			expect_reg(sample_queue_pkg::ADDR_EVENT_SOURCE, 8'h04); // Event level
			push(410, 2);
			expect_reg(sample_queue_pkg::ADDR_LEVEL_STATUS, tbefore[m] + 8'h02); // After
		end
		push(500, 130);
		expect_reg(sample_queue_pkg::ADDR_FLAG_STATUS, 8'h20); // Stopped when full, no overrun
		i_trigger_event = 1'b0;
		expect_reg(sample_queue_pkg::ADDR_EVENT_SETUP, 8'h01); // Setup register read back
		$display("test triggered done");
		results();
	end

endmodule : tb_pressure_temp_sample_fifo
